// ==== wit_channel_top.sv ====
// Watchdog / interval timer channel: keyed word writes, 8-bit counter,
// overflow flag, watchdog reset or NMI, interval interrupt.
// Assumes a synchronous processor bus with a one-cycle write strobe and
// that the chip routes chip_reset_o to the reset vector logic.
`default_nettype none

// Function
// - Counter wrap from FF to 00 sets the wrap flag.
// - Watchdog internal reset clears the wrap flag by itself.
// - Flag clears by reading it as 1, then writing 0.
// - Writing count_enable as 0 also clears the wrap flag.
// - Writing 1 to the wrap flag does nothing.
// - Bit 6 picks interval (0) or watchdog (1) mode; resets to 0.
// - Counter runs while bit 5 is 1; clearing it zeroes the counter.
// - Bit 4 picks main (0) or sub-clock (1) prescaler.
// - Bit 3 picks NMI (0) or internal reset (1) on watchdog overflow.
// - Main divisors 2,64,128,512,2048,8192,32768,131072 by code.
// - Sub divisors 2,4,8,16,32,64,128,256 by code.
// - Watchdog mode and enabled: overflow fires reset or NMI.
// - Internal reset lasts 518 clocks, reset-out low 132 clocks.
// - NMI option raises NMI and leaves reset-out high.
// - Reset source flag: external reset wins and sets it to 1.
// - Interval interrupt asserts in the cycle the flag sets.
// - Flag sets; internal reset and reset-out low start together.
// - Counter is an 8-bit readable and writable up-counter.
// - Shared write address, word writes keyed 5A/A5; bytes ignored.
// - Counter write beats a same-cycle increment.
module wit_channel_top
  import wit_pkg::*;
#(
  parameter int COUNT_W = 8
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sub_clk_i,
  input wire logic bus_wr_i,
  input wire logic bus_word_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic bus_rd_i,
  input wire logic bus_rsel_i,
  input wire logic external_reset_n_i,
  output logic [7:0] bus_rdata_o,
  output logic interval_irq_o,
  output logic wdt_nmi_o,
  output logic chip_reset_o,
  output logic reset_out_n_o,
  output logic reset_source_flag_o
);
  wit_ctl_if ctl ();

  logic [CTL_W-1:0] ctl_r;
  logic [CTL_W-1:0] ctl_nxt;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic flag_r;
  logic flag_nxt;
  logic armed_r;
  logic armed_nxt;
  logic nmi_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic src_flag_r;
  logic src_flag_nxt;

  wire logic mode_guard;
  wire logic cnt_en;
  wire logic act_reset;
  wire logic wr_word;
  wire logic cnt_wr;
  wire logic st_wr;
  wire logic st_rd;
  wire logic chip_rst;
  wire logic wrap;
  wire logic guard_hit;
  wire logic rd_clr;
  wire logic tme_clr;
  wire logic [7:0] wdata_lo;
  wire logic [7:0] status_view;

  // Control field decode
  assign mode_guard = ctl_r[BIT_MODE];
  assign cnt_en = ctl_r[BIT_EN];
  assign act_reset = ctl_r[BIT_ACT];
  assign ctl.src_sel = ctl_r[BIT_SRC];
  assign ctl.div_sel = ctl_r[BIT_DIV_HI:BIT_DIV_LO];
  assign chip_rst = ctl.int_rst;

  // Keyed write decode; byte writes never match so they are dropped
  assign wdata_lo = bus_wdata_i[7:0];
  assign wr_word = bus_wr_i & bus_word_i;
  assign cnt_wr = wr_word & (bus_wdata_i[15:8] == KEY_COUNTER);
  assign st_wr = wr_word & (bus_wdata_i[15:8] == KEY_STATUS);
  assign st_rd = bus_rd_i & ~bus_rsel_i;

  // Overflow detection; a same-cycle counter write hides the wrap
  assign wrap = cnt_en & ctl.tick & ~cnt_wr & ~chip_rst &
    (count_r == COUNT_MAX);
  assign guard_hit = wrap & mode_guard;
  assign ctl.start = guard_hit & act_reset;

  // Flag clear terms
  assign rd_clr = st_wr & ~bus_wdata_i[BIT_FLAG] & armed_r;
  assign tme_clr = st_wr & ~bus_wdata_i[BIT_EN];
  assign status_view = {flag_r, ctl_r};

  // Next control value; the internal reset returns it to defaults
  always_comb
  begin
    ctl_nxt = ctl_r;
    if (chip_rst)
      ctl_nxt = CTL_RESET;
    else if (st_wr)
      ctl_nxt = bus_wdata_i[CTL_W-1:0];
  end

  // Counter: stop-and-zero, then write, then increment
  always_comb
  begin
    count_nxt = count_r;
    if (chip_rst || !cnt_en)
      count_nxt = COUNT_RESET;
    else if (cnt_wr)
      count_nxt = wdata_lo;
    else if (ctl.tick)
      count_nxt = count_r + COUNT_ONE;
  end

  // Flag: a wrap in the clearing cycle still sets it
  always_comb
  begin
    flag_nxt = flag_r;
    if (rd_clr || tme_clr || chip_rst)
      flag_nxt = 1'b0;
    if (wrap)
      flag_nxt = 1'b1;
  end

  // Read arming: only a read that saw the flag set permits a clear
  always_comb
  begin
    armed_nxt = armed_r;
    if (chip_rst || st_wr || !flag_r)
      armed_nxt = 1'b0;
    else if (st_rd)
      armed_nxt = 1'b1;
  end

  // Read data, registered one cycle after the strobe
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (bus_rd_i)
      rdata_nxt = bus_rsel_i ? count_r : status_view;
  end

  // Reset source: the external pin wins over a same-cycle watchdog reset
  always_comb
  begin
    src_flag_nxt = src_flag_r;
    if (!external_reset_n_i)
      src_flag_nxt = 1'b1;
    else if (ctl.start)
      src_flag_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctl_r <= CTL_RESET;
      count_r <= COUNT_RESET;
      flag_r <= 1'b0;
      armed_r <= 1'b0;
      rdata_r <= COUNT_RESET;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      count_r <= count_nxt;
      flag_r <= flag_nxt;
      armed_r <= armed_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // NMI pulse and source flag; system reset counts as an external one
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      nmi_r <= 1'b0;
      src_flag_r <= 1'b1;
    end
    else
    begin
      nmi_r <= guard_hit & ~act_reset;
      src_flag_r <= src_flag_nxt;
    end
  end

  // Prescaler and reset pulser
  wit_prescaler u_pre (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .sub_clk_i(sub_clk_i),
    .ctl(ctl.pre)
  );

  wit_reset_pulse u_pulse (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ctl(ctl.pulse)
  );

  // Outputs; interrupt follows the flag directly so it rises with it
  assign interval_irq_o = flag_r & ~mode_guard;
  assign wdt_nmi_o = nmi_r;
  assign chip_reset_o = chip_rst;
  assign reset_out_n_o = ctl.rst_out_n;
  assign reset_source_flag_o = src_flag_r;
  assign bus_rdata_o = rdata_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  flag_set_a:
    assert property (wrap |=> flag_r)
    else $error("wrap did not set the flag");
  auto_clear_a:
    assert property (ctl.start |-> ##2 !flag_r && chip_reset_o)
    else $error("internal reset did not clear the flag");
  clear_cause_a:
    assert property ($fell(flag_r) |-> $past(rd_clr) || $past(tme_clr) || $past(chip_rst))
    else $error("flag cleared without a legal cause");
  tme_clear_a:
    assert property (tme_clr && !wrap |=> !flag_r)
    else $error("disabling did not clear the flag");
  one_ignored_a:
    assert property (st_wr && bus_wdata_i[BIT_FLAG] && !flag_r && !wrap |=> !flag_r)
    else $error("writing 1 set the flag");
  stop_zero_a:
    assert property (!cnt_en |=> count_r == COUNT_RESET)
    else $error("stopped counter is not zero");
  write_wins_a:
    assert property (cnt_wr && cnt_en && !chip_rst |=> count_r == $past(wdata_lo))
    else $error("counter write lost");
  count_step_a:
    assert property (cnt_en && ctl.tick && !cnt_wr && !chip_rst
      |=> count_r == COUNT_W'($past(count_r) + COUNT_ONE))
    else $error("counter did not step by one");
  nmi_path_a:
    assert property (guard_hit && !act_reset |=> wdt_nmi_o && reset_out_n_o && !chip_reset_o)
    else $error("NMI option misbehaved");
  irq_same_a:
    assert property (wrap && !mode_guard && !st_wr |=> interval_irq_o && flag_r)
    else $error("interval interrupt late");
  ext_wins_a:
    assert property (!external_reset_n_i |=> reset_source_flag_o)
    else $error("external reset did not set source flag");

  cover_interval: cover property (wrap && !mode_guard);
  cover_reset: cover property (ctl.start);
  cover_nmi: cover property (guard_hit && !act_reset);
  cover_clear: cover property (rd_clr && flag_r);
endmodule
`default_nettype wire

// ==== wit_channel_top_tb.sv ====
// Self-checking bench for the watchdog/interval timer channel.
// Assumes wit_sys_model supplies the sub-clock and the external reset pin.
`default_nettype none
module wit_channel_top_tb
  import wit_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, sys_rst_i, sub_clk_i, bus_wr_i, bus_word_i, bus_rd_i, bus_rsel_i;
  logic [15:0] bus_wdata_i;
  logic external_reset_n_i, ext_req, rd_note;
  logic mark = 1'b0;
  int nmi_hits = 0;
  logic [7:0] bus_rdata_o;
  logic interval_irq_o, wdt_nmi_o, chip_reset_o, reset_out_n_o, reset_source_flag_o;
  logic [31:0] seed = 32'h5071;
  logic [7:0] exp_q[$];
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int mdiv[5] = '{2, 64, 128, 512, 2048};

  wit_channel_top dut (.sys_clk_i, .sys_rst_i, .sub_clk_i, .bus_wr_i, .bus_word_i,
    .bus_wdata_i, .bus_rd_i, .bus_rsel_i, .external_reset_n_i, .bus_rdata_o,
    .interval_irq_o, .wdt_nmi_o, .chip_reset_o, .reset_out_n_o, .reset_source_flag_o);
  wit_sys_model far (.sys_clk_i, .ext_req_i(ext_req), .sub_clk_o(sub_clk_i),
    .external_reset_n_o(external_reset_n_i));

  // 50 MHz system clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, want);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  // Strobes stay up across back-to-back calls of one task; nop drops both, wr and rd drop each other's
  task automatic nop();
    bus_rd_i = 1'b0;
    bus_wr_i = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [15:0] d, input logic word);
    bus_rd_i = 1'b0;
    bus_wr_i = 1'b1;
    bus_word_i = word;
    bus_wdata_i = d;
    @(posedge sys_clk_i);
    #1;
  endtask

  // A noted read leaves its expected byte for the monitor
  task automatic rd(input logic s, input logic [7:0] e, input logic note,
    output logic [7:0] v);
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b1;
    bus_rsel_i = s;
    rd_note = note;
    if (note)
      exp_q.push_back(e);
    @(posedge sys_clk_i);
    #1;
    v = bus_rdata_o;
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: sig = interval_irq_o;
      1: sig = wdt_nmi_o;
      default: sig = chip_reset_o;
    endcase
  endfunction

  task automatic wait_sig(input int w, input int lim);
    for (int k = 0; k < lim && sig(w) !== 1'b1; k++)
      nop();
  endtask

  // Spacing between two counter changes, polled every clock
  task automatic period(input int n);
    logic [7:0] a, b;
    int t0;
    rd(1'b1, 8'h00, 1'b0, a);
    b = a;
    for (int k = 0; k < 2 * n + 4 && b === a; k++)
      rd(1'b1, 8'h00, 1'b0, b);
    t0 = cyc;
    a = b;
    for (int k = 0; k < 2 * n + 4 && b === a; k++)
      rd(1'b1, 8'h00, 1'b0, b);
    check(cyc - t0, n);
  endtask

  // Read results stand from the edge that takes the read; look half a clock
  // later so the compare never races the register update
  always @(negedge sys_clk_i)
  begin
    if (mark)
      check(bus_rdata_o, exp_q.pop_front());
    mark <= bus_rd_i & rd_note;
    if (wdt_nmi_o === 1'b1)
      nmi_hits++;
  end

  // Hang guard, well above the longest expected run
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      give_verdict();
    end
  end

  initial
  begin
    logic [7:0] v;
    int nh, nl, n0;
    sys_rst_i = 1'b1;
    bus_wr_i = 1'b0;
    bus_word_i = 1'b1;
    bus_wdata_i = 16'h0000;
    bus_rd_i = 1'b0;
    bus_rsel_i = 1'b0;
    ext_req = 1'b0;
    rd_note = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    rd(1'b0, 8'h00, 1'b1, v);
    rd(1'b1, 8'h00, 1'b1, v);
    check(reset_source_flag_o, 1);
    // Interval wrap, then the flag clear handshake
    wr({KEY_STATUS, 8'h20}, 1'b1);
    wr({KEY_COUNTER, 8'hFF}, 1'b1);
    wait_sig(0, 8);
    check(interval_irq_o, 1);
    wr({KEY_STATUS, 8'hA0}, 1'b1);
    wr({KEY_STATUS, 8'h20}, 1'b1);
    rd(1'b0, 8'hA0, 1'b1, v);
    rd(1'b0, 8'hA0, 1'b1, v);
    wr({KEY_STATUS, 8'h20}, 1'b1);
    rd(1'b0, 8'h20, 1'b1, v);
    check(interval_irq_o, 0);
    // Byte write and a random wrong key must both be ignored
    seed = lfsr(seed);
    wr({KEY_STATUS, seed[7:0]}, 1'b0);
    seed = lfsr(seed);
    wr({seed[15:8] & 8'h3C, seed[7:0]}, 1'b1);
    rd(1'b0, 8'h20, 1'b1, v);
    wait_sig(0, 600);
    check(interval_irq_o, 1);
    wr({KEY_STATUS, 8'h00}, 1'b1);
    rd(1'b0, 8'h00, 1'b1, v);
    rd(1'b1, 8'h00, 1'b1, v);
    // Divisor codes, stopping the timer before each change
    for (int c = 0; c < 5; c++)
    begin
      wr({KEY_STATUS, 8'h00}, 1'b1);
      wr({KEY_STATUS, 8'h20 | 8'(c)}, 1'b1);
      period(mdiv[c]);
    end
    for (int c = 0; c < 8; c++)
    begin
      wr({KEY_STATUS, 8'h00}, 1'b1);
      wr({KEY_STATUS, 8'h30 | 8'(c)}, 1'b1);
      period(8 << c);
    end
    // Watchdog kept alive by rewrites, then left to fire an NMI
    wr({KEY_STATUS, 8'h00}, 1'b1);
    wr({KEY_STATUS, 8'h60}, 1'b1);
    n0 = nmi_hits;
    // Odd loop length moves the rewrite across both tick phases
    repeat (5)
    begin
      repeat (299) nop();
      wr({KEY_COUNTER, 8'h00}, 1'b1);
      rd(1'b1, 8'h00, 1'b1, v);
    end
    check(nmi_hits - n0, 0);
    wr({KEY_COUNTER, 8'hFF}, 1'b1);
    // The far side has no NMI pin, so the watchdog NMI is never shared
    wait_sig(1, 8);
    check(wdt_nmi_o, 1);
    check(reset_out_n_o, 1);
    check(chip_reset_o, 0);
    // Watchdog internal reset and reset-out pulse lengths
    wr({KEY_STATUS, 8'h00}, 1'b1);
    wr({KEY_STATUS, 8'h68}, 1'b1);
    wr({KEY_COUNTER, 8'hFF}, 1'b1);
    wait_sig(2, 8);
    check(reset_out_n_o, 0);
    check(reset_source_flag_o, 0);
    nh = 0;
    nl = 0;
    while (chip_reset_o === 1'b1 && nh < 700)
    begin
      nh++;
      if (reset_out_n_o === 1'b0)
        nl++;
      nop();
    end
    check(nh, 518);
    check(nl, 132);
    rd(1'b0, 8'h00, 1'b1, v);
    ext_req = 1'b1;
    nop();
    ext_req = 1'b0;
    repeat (6) nop();
    check(reset_source_flag_o, 1);
    nop();
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== wit_ctl_if.sv ====
// Carrier between the channel core, its prescaler and its reset pulser.
// Assumes all three sit on the same system clock.
`default_nettype none
interface wit_ctl_if;
  logic src_sel;
  logic [2:0] div_sel;
  logic tick;
  logic start;
  logic int_rst;
  logic rst_out_n;
  modport pre (input src_sel, input div_sel, output tick);
  modport pulse (input start, output int_rst, output rst_out_n);
  modport core (output src_sel, output div_sel, output start,
    input tick, input int_rst, input rst_out_n);
endinterface
`default_nettype wire

// ==== wit_pkg.sv ====
// Constants and types shared by the watchdog/interval timer channel.
// Assumes one system clock; all users import the whole package.
`default_nettype none
package wit_pkg;
  // Keys carried in the upper byte of a word write
  localparam logic [7:0] KEY_COUNTER = 8'h5A;
  localparam logic [7:0] KEY_STATUS = 8'hA5;
  // Control/status bit positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_MODE = 6;
  localparam int BIT_EN = 5;
  localparam int BIT_SRC = 4;
  localparam int BIT_ACT = 3;
  localparam int BIT_DIV_HI = 2;
  localparam int BIT_DIV_LO = 0;
  localparam int CTL_W = 7;
  // Reset values and counter limits
  localparam logic [6:0] CTL_RESET = 7'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  // Internal reset length and pin pulse length, both in system clocks
  localparam int INT_RST_CLKS = 518;
  localparam int RST_OUT_CLKS = 132;
  localparam int RST_CNT_W = 10;
  // Prescaler widths: main reaches /131072, sub reaches /256
  localparam int MAIN_PRE_W = 17;
  localparam int SUB_PRE_W = 8;
  typedef enum logic [1:0] {WIT_IDLE, WIT_BOTH, WIT_INT_ONLY} wit_pulse_state_t;
  // Main prescaler bit whose rising edge gives the chosen divisor
  function automatic logic [4:0] wit_main_tap(input logic [2:0] sel);
    case (sel)
      3'h0: wit_main_tap = 5'h00;
      3'h1: wit_main_tap = 5'h05;
      3'h2: wit_main_tap = 5'h06;
      3'h3: wit_main_tap = 5'h08;
      3'h4: wit_main_tap = 5'h0A;
      3'h5: wit_main_tap = 5'h0C;
      3'h6: wit_main_tap = 5'h0E;
      default: wit_main_tap = 5'h10;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== wit_prescaler.sv ====
// Main and sub-clock prescalers with tap selection, one tick per divided edge.
// Assumes sub_clk_i is already synchronous to sys_clk_i.
`default_nettype none
module wit_prescaler
  import wit_pkg::*;
#(
  parameter int MAIN_W = MAIN_PRE_W,
  parameter int SUB_W = SUB_PRE_W
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic sub_clk_i,
  wit_ctl_if.pre ctl
);
  logic [MAIN_W-1:0] main_cnt_r;
  logic [SUB_W-1:0] sub_cnt_r;
  logic sub_prev_r;
  logic tap_prev_r;
  wire logic sub_edge;
  wire logic tap_main;
  wire logic tap_sub;
  wire logic tap_now;
  logic [3:0] sel_prev_r;
  wire logic [3:0] sel_now;
  wire logic sel_same;

  // Tap selection; after a selection change the old and new taps are
  // different divider bits, so that one cycle gives no tick
  assign sel_now = {ctl.src_sel, ctl.div_sel};
  assign sel_same = (sel_now == sel_prev_r);
  assign sub_edge = sub_clk_i & ~sub_prev_r;
  assign tap_main = main_cnt_r[wit_main_tap(ctl.div_sel)];
  assign tap_sub = sub_cnt_r[ctl.div_sel];
  assign tap_now = ctl.src_sel ? tap_sub : tap_main;
  assign ctl.tick = tap_now & ~tap_prev_r & sel_same;

  // Free-running dividers, sub divider advances on sub-clock edges
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      main_cnt_r <= '0;
      sub_cnt_r <= '0;
      sub_prev_r <= 1'b0;
      tap_prev_r <= 1'b0;
      sel_prev_r <= '0;
    end
    else
    begin
      main_cnt_r <= main_cnt_r + 1'b1;
      sub_cnt_r <= sub_edge ? sub_cnt_r + 1'b1 : sub_cnt_r;
      sub_prev_r <= sub_clk_i;
      tap_prev_r <= tap_now;
      sel_prev_r <= sel_now;
    end
  end
endmodule
`default_nettype wire

// ==== wit_reset_pulse.sv ====
// Timed internal reset and reset-out pin pulse after a watchdog overflow.
// Assumes the pulser itself is not cleared by the reset it produces.
`default_nettype none
module wit_reset_pulse
  import wit_pkg::*;
#(
  parameter int INT_CLKS = INT_RST_CLKS,
  parameter int OUT_CLKS = RST_OUT_CLKS
)
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  wit_ctl_if.pulse ctl
);
  localparam logic [RST_CNT_W-1:0] INT_LAST = RST_CNT_W'(INT_CLKS);
  localparam logic [RST_CNT_W-1:0] OUT_LAST = RST_CNT_W'(OUT_CLKS);
  localparam logic [RST_CNT_W-1:0] CNT_ONE = RST_CNT_W'(1);
  wit_pulse_state_t state_r;
  wit_pulse_state_t state_nxt;
  logic [RST_CNT_W-1:0] cnt_r;
  logic [RST_CNT_W-1:0] cnt_nxt;

  // Both lines start together; the pin releases first
  assign ctl.int_rst = (state_r != WIT_IDLE);
  assign ctl.rst_out_n = (state_r != WIT_BOTH);

  // Sequencer: counts active cycles from one
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + CNT_ONE;
    case (state_r)
      WIT_IDLE:
      begin
        cnt_nxt = CNT_ONE;
        if (ctl.start)
          state_nxt = WIT_BOTH;
      end
      WIT_BOTH:
        if (cnt_r == OUT_LAST)
          state_nxt = WIT_INT_ONLY;
      WIT_INT_ONLY:
        if (cnt_r == INT_LAST)
          state_nxt = WIT_IDLE;
      default:
        state_nxt = WIT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= WIT_IDLE;
      cnt_r <= CNT_ONE;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  pin_pulse_len_a:
    assert property ($fell(ctl.rst_out_n) |-> ##132 $rose(ctl.rst_out_n))
    else $error("reset-out pulse is not 132 clocks");
  int_reset_len_a:
    assert property ($rose(ctl.int_rst) |-> ##[518:518] $fell(ctl.int_rst))
    else $error("internal reset is not 518 clocks");
  both_start_a:
    assert property ($rose(ctl.int_rst) |-> $fell(ctl.rst_out_n))
    else $error("internal reset and reset-out did not start together");
endmodule
`default_nettype wire

// ==== wit_sys_model.sv ====
// Far-side model: free-running sub-clock source and the external reset pin.
// Assumes the bench raises ext_req_i for one cycle to ask for a pin reset.
`default_nettype none
module wit_sys_model
(
  input wire logic sys_clk_i,
  input wire logic ext_req_i,
  output logic sub_clk_o,
  output logic external_reset_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase_r = 2'h0;
  int hold = 0;
  // Sub-clock runs free: one rising edge every four system clocks
  assign sub_clk_o = phase_r[1];
  always @(posedge sys_clk_i)
    phase_r <= #1 phase_r + 2'h1;
  // Pin reset held low for four clocks, high (pulled up) otherwise
  always @(posedge sys_clk_i)
    hold <= #1 ext_req_i ? 4 : (hold > 0 ? hold - 1 : 0);
  assign external_reset_n_o = (hold == 0);
endmodule
`default_nettype wire
